// ---- src/data_move_multiply_exec.sv ----
`timescale 1ns/1ns
module data_move_multiply_exec (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic extended_en,
   input wire logic [11:0] index_base,
   input wire logic [7:0] mem_rdata,
   output exec_pkg::mem_req_t mem_req,
   output exec_pkg::phase_t phase,
   output logic [7:0] accumulator_q,
   output logic [7:0] bank_select_q,
   output exec_pkg::product_t product_q,
   output logic instr_done_q,
   output logic copy_busy_q
);
   import exec_pkg::*;

   logic [15:0] ir_q;
   logic second_q;
   logic [7:0] data_q;
   logic [11:0] store_addr;
   logic [11:0] dest_addr;
   logic copy_start;
   logic is_copy1;
   logic is_copy2;
   logic is_bank;
   logic is_lacc;
   logic is_mul;
   logic is_store;
   logic [15:0] product_d;

   phase_counter u_phase (
      .clock(clock),
      .sys_rst(sys_rst),
      .phase(phase)
   );

   address_former u_addr (
      .file_addr(ir_q[7:0]),
      .access_sel(ir_q[STORE_ACCESS_BIT]),
      .extended_en(extended_en),
      .bank_sel(bank_select_q),
      .index_base(index_base),
      .full_addr(store_addr)
   );

   // The source read is decoded from the fetched word itself, so it lands in the read phase.
   assign copy_start = instr_valid && !second_q && instr_word[15:12] == OP_COPY_FIRST;
   assign is_copy1 = !second_q && ir_q[15:12] == OP_COPY_FIRST;
   assign is_copy2 = second_q && ir_q[15:12] == OP_COPY_SECOND;
   assign is_bank = !second_q && ir_q[15:8] == OP_LOAD_BANK;
   assign is_lacc = !second_q && ir_q[15:8] == OP_LOAD_ACC;
   assign is_mul = !second_q && ir_q[15:8] == OP_MULTIPLY;
   assign is_store = !second_q && ir_q[15:9] == OP_STORE_ACC;
   assign dest_addr = ir_q[11:0];
   assign product_d = accumulator_q * ir_q[7:0];

   // Instruction latched at decode; an invalid fetch becomes a no-op.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ir_q <= 16'h0000;
      end else if (phase == PH_DECODE) begin
         ir_q <= instr_valid ? instr_word : 16'h0000;
      end
   end

   // Second-word tracking for the two-word copy.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         second_q <= 1'b0;
         copy_busy_q <= 1'b0;
      end else if (phase == PH_WRITE) begin
         second_q <= is_copy1;
         copy_busy_q <= is_copy1;
      end
   end

   // Source byte captured in the first cycle, held for the second.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         data_q <= 8'h00;
      end else if (phase == PH_PROCESS && is_copy1) begin
         // The accumulator is not held in memory, so a copy from it takes the register.
         data_q <= (ir_q[11:0] == ACC_ADDR) ? accumulator_q : mem_rdata;
      end
   end

   // Memory requests: reads in phase two, writes in phase four only.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mem_req <= '0;
      end else begin
         mem_req <= '0;
         if (phase == PH_DECODE && copy_start) begin
            mem_req.rd_en <= 1'b1;
            mem_req.addr <= instr_word[11:0];
         end else if (phase == PH_PROCESS && is_copy2) begin
            // The accumulator lives in the data space, so a copy into it
            // is routed to the register below as well as to memory.
            mem_req.wr_en <= 1'b1;
            mem_req.addr <= dest_addr;
            mem_req.wdata <= data_q;
         end else if (phase == PH_PROCESS && is_store) begin
            mem_req.wr_en <= 1'b1;
            mem_req.addr <= store_addr;
            mem_req.wdata <= accumulator_q;
         end
      end
   end

   // Accumulator: literal load, or a copy that names it as destination.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         accumulator_q <= ACC_RESET;
      end else if (phase == PH_PROCESS && is_lacc) begin
         accumulator_q <= ir_q[7:0];
      end else if (phase == PH_PROCESS && is_copy2 && dest_addr == ACC_ADDR) begin
         accumulator_q <= data_q;
      end
   end

   // Upper nibble forced to zero whatever the literal holds.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bank_select_q <= BANK_RESET;
      end else if (phase == PH_PROCESS && is_bank) begin
         bank_select_q <= {4'h0, ir_q[3:0] & BANK_NIBBLE_MASK};
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         product_q <= '0;
      end else if (phase == PH_PROCESS && is_mul) begin
         product_q <= product_d;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         instr_done_q <= 1'b0;
      end else begin
         instr_done_q <= (phase == PH_PROCESS) && !is_copy1;
      end
   end

   a_bank_upper_zero: assert property (@(posedge clock) disable iff (sys_rst)
      bank_select_q[7:4] == 4'h0) else $error("bank select upper nibble set");
   a_lacc_loads: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_lacc) |=> accumulator_q == $past(ir_q[7:0]))
      else $error("literal not loaded");
   a_bank_loads: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_bank) |=> bank_select_q[3:0] == $past(ir_q[3:0]))
      else $error("bank literal not loaded");
   a_mul_product: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_mul) |=> (product_q == $past(product_d))
      && $stable(accumulator_q)) else $error("product wrong");
   a_copy_write_time: assert property (@(posedge clock) disable iff (sys_rst)
      mem_req.wr_en |-> phase == PH_WRITE) else $error("write outside phase four");
   a_copy_read_first: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_DECODE && copy_start) |=> (mem_req.rd_en
      && mem_req.addr == $past(instr_word[11:0])) ##3 copy_busy_q)
      else $error("copy read missing");
   a_copy_data_same: assert property (@(posedge clock) disable iff (sys_rst)
      (mem_req.wr_en && copy_busy_q) |-> mem_req.wdata == data_q)
      else $error("copy data altered");
   a_store_data: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_store) |=> mem_req.wr_en
      && mem_req.wdata == $past(accumulator_q)) else $error("store wrong");
   a_store_bank: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_store && ir_q[STORE_ACCESS_BIT]) |=>
      mem_req.addr[11:8] == bank_select_q[3:0]) else $error("bank address wrong");
   a_indexed: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_store && !ir_q[STORE_ACCESS_BIT] && extended_en
      && ir_q[7:0] <= INDEXED_LIMIT) |=> mem_req.addr == $past(index_base + 12'(ir_q[7:0])))
      else $error("indexed address wrong");
   a_copy_to_acc: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_copy2 && dest_addr == ACC_ADDR) |=> accumulator_q
      == $past(data_q)) else $error("copy into accumulator lost");
   a_copy_from_acc: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_PROCESS && is_copy1 && ir_q[11:0] == ACC_ADDR) |=> data_q
      == $past(accumulator_q)) else $error("copy from accumulator lost");
   a_done_phase: assert property (@(posedge clock) disable iff (sys_rst)
      instr_done_q |-> phase == PH_WRITE) else $error("done outside phase four");
   a_copy_no_early_done: assert property (@(posedge clock) disable iff (sys_rst)
      (phase == PH_DECODE && copy_start) |=> ##2 !instr_done_q)
      else $error("copy done after first word");
   c_copy: cover property (@(posedge clock) disable iff (sys_rst) mem_req.wr_en && copy_busy_q);
   c_mul: cover property (@(posedge clock) disable iff (sys_rst) phase == PH_PROCESS && is_mul);
   c_store_idx: cover property (@(posedge clock) disable iff (sys_rst)
      phase == PH_PROCESS && is_store && extended_en && !ir_q[STORE_ACCESS_BIT]);
endmodule : data_move_multiply_exec

// ---- inc/exec_pkg.sv ----
// What this block does
// - Copy moves source byte unchanged, no flags
// - Copy words: 1100+source, 1111+destination
// - Accumulator may be copy source or destination
// - Copy: read cycle one, write phase four
// - Bank literal load writes bank select
// - Bank select upper nibble always reads zero
// - Accumulator literal load, one cycle, no flags
// - Store accumulator into addressed bank register
// - Access bit zero: access bank; one: bank
// - Extended set, access bit zero, low address: indexed offset mode
// - Multiply literal gives unsigned 16-bit product
package exec_pkg;
   localparam logic [3:0] OP_COPY_FIRST = 4'hC;
   localparam logic [3:0] OP_COPY_SECOND = 4'hF;
   localparam logic [7:0] OP_LOAD_BANK = 8'h01;
   localparam logic [7:0] OP_LOAD_ACC = 8'h0E;
   localparam logic [7:0] OP_MULTIPLY = 8'h0D;
   localparam logic [6:0] OP_STORE_ACC = 7'h37;
   localparam int STORE_ACCESS_BIT = 8;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [11:0] ACC_ADDR = 12'hFE8;
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] BANK_NIBBLE_MASK = 4'hF;

   typedef enum logic [1:0] {
      PH_DECODE = 2'b00,
      PH_READ = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE = 2'b11
   } phase_t;

   typedef struct packed {
      logic rd_en;
      logic wr_en;
      logic [11:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } product_t;
endpackage : exec_pkg

// ---- src/phase_counter.sv ----
`timescale 1ns/1ns
module phase_counter (
   input wire logic clock,
   input wire logic sys_rst,
   output exec_pkg::phase_t phase
);
   import exec_pkg::*;

   // Four clocks make one instruction cycle.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= PH_DECODE;
      end else begin
         phase <= phase_t'(phase + 2'd1);
      end
   end
endmodule : phase_counter

// ---- src/address_former.sv ----
`timescale 1ns/1ns
module address_former (
   input wire logic [7:0] file_addr,
   input wire logic access_sel,
   input wire logic extended_en,
   input wire logic [7:0] bank_sel,
   input wire logic [11:0] index_base,
   output logic [11:0] full_addr
);
   import exec_pkg::*;

   always_comb begin
      if (!access_sel && extended_en && file_addr <= INDEXED_LIMIT) begin
         full_addr = index_base + {4'h0, file_addr};
      end else if (!access_sel) begin
         // The access bank covers low RAM and the top special registers.
         full_addr = (file_addr < ACCESS_SPLIT) ? {4'h0, file_addr}
                     : {ACCESS_HIGH_BANK, file_addr};
      end else begin
         full_addr = {bank_sel[3:0], file_addr};
      end
   end
endmodule : address_former

// ---- verification/data_memory_model.sv ----
`timescale 1ns/1ns
module data_memory_model (
   input wire logic clock,
   input exec_pkg::mem_req_t mem_req,
   output logic [7:0] mem_rdata
);
   import exec_pkg::*;
   logic [7:0] mem [4096];
   initial mem_rdata = 8'h00;
   // Between reads the data line inverts every clock, so a sample one cycle late sees the complement of the read byte.
   always @(posedge clock) begin
      if (mem_req.rd_en) begin
         mem_rdata <= mem[mem_req.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_req.wr_en) begin
         mem[mem_req.addr] <= mem_req.wdata;
      end
   end
endmodule : data_memory_model

// ---- verification/test_data_move_multiply_exec.sv ----
`timescale 1ns/1ns
`define CHECK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module test_data_move_multiply_exec;
   import exec_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] instr_word = 16'h0000;
   logic instr_valid = 1'b0;
   logic extended_en = 1'b0;
   logic [11:0] index_base = 12'h000;
   logic [7:0] mem_rdata;
   mem_req_t mem_req;
   phase_t phase;
   logic [7:0] accumulator_q, bank_select_q;
   product_t product_q;
   int fail_count = 0;
   int checks = 0;
   logic [31:0] seed = 32'h4999;
   logic [7:0] k, v;
   logic [11:0] src, dst;
   logic [3:0] bk = 4'h0;
   logic [7:0] corner [5] = '{8'h5F, 8'h60, 8'h7F, 8'h80, 8'h00};
   always #10 clock = ~clock;
   data_move_multiply_exec dut (.clock(clock), .sys_rst(sys_rst), .instr_word(instr_word),
      .instr_valid(instr_valid), .extended_en(extended_en), .index_base(index_base),
      .mem_rdata(mem_rdata), .mem_req(mem_req), .phase(phase), .accumulator_q(accumulator_q),
      .bank_select_q(bank_select_q), .product_q(product_q), .instr_done_q(), .copy_busy_q());
   data_memory_model model (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [11:0] store_addr(input logic [7:0] f, input logic a,
      input logic ext, input logic [11:0] base);
      if (!a && ext && f <= INDEXED_LIMIT) return base + {4'h0, f};
      if (!a) return (f >= ACCESS_SPLIT) ? {ACCESS_HIGH_BANK, f} : {4'h0, f};
      return {bk, f};
   endfunction : store_addr
   task automatic sync();
      do @(negedge clock); while (phase !== PH_WRITE);
   endtask : sync
   // Words are handed over only at the edge that ends a write phase, so they meet decode.
   task automatic run(input logic [15:0] w1, input logic [15:0] w2, input bit two);
      sync();
      @(posedge clock) begin instr_word <= w1; instr_valid <= 1'b1; end
      if (two) begin
         sync();
         @(posedge clock) instr_word <= w2;
      end
      sync();
      @(posedge clock) instr_valid <= 1'b0;
      @(negedge clock);
   endtask : run
   task automatic store(input logic [7:0] f, input logic a, input logic ext,
      input logic [11:0] base);
      logic [11:0] ea;
      ea = store_addr(f, a, ext, base);
      @(posedge clock) begin extended_en <= ext; index_base <= base; end
      run({OP_STORE_ACC, a, f}, 16'h0000, 1'b0);
      `CHECK(model.mem[ea], k)
   endtask : store
   task automatic tally_and_finish();
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   initial begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         run({OP_LOAD_BANK, seed[7:0]}, 16'h0000, 1'b0);
         `CHECK(bank_select_q, {4'h0, seed[3:0]})
         bk = seed[3:0];
         seed = lfsr(seed);
         k = seed[15:8];
         run({OP_LOAD_ACC, k}, 16'h0000, 1'b0);
         `CHECK(accumulator_q, k)
         run({OP_MULTIPLY, seed[7:0]}, 16'h0000, 1'b0);
         `CHECK(product_q, {8'h00, k} * {8'h00, seed[7:0]})
         `CHECK(accumulator_q, k)
         store(seed[31:24], seed[17], seed[16], seed[27:16]);
         seed = lfsr(seed);
         src = (seed[11:0] == ACC_ADDR) ? 12'h123 : seed[11:0];
         dst = seed[23:12];
         // Counter and stack bytes are never a copy target.
         if (dst >= 12'hFFD || dst == 12'hFF9 || dst == ACC_ADDR) dst = dst ^ 12'h100;
         v = seed[31:24];
         model.mem[src] = v;
         run({OP_COPY_FIRST, src}, {OP_COPY_SECOND, dst}, 1'b1);
         `CHECK(model.mem[dst], v)
         `CHECK(accumulator_q, k)
      end
      foreach (corner[j]) store(corner[j], 1'b0, 1'b1, 12'h300);
      model.mem[12'h000] = 8'hA5;
      run({OP_COPY_FIRST, 12'h000}, {OP_COPY_SECOND, ACC_ADDR}, 1'b1);
      `CHECK(accumulator_q, 8'hA5)
      // The memory copy of the accumulator address is spoiled, so only the register can pass.
      model.mem[ACC_ADDR] = 8'h00;
      run({OP_COPY_FIRST, ACC_ADDR}, {OP_COPY_SECOND, 12'h010}, 1'b1);
      `CHECK(model.mem[12'h010], 8'hA5)
      model.mem[12'h000] = 8'h3C;
      run({OP_COPY_SECOND, 12'h000}, 16'h0000, 1'b0);
      `CHECK(model.mem[12'h000], 8'h3C)
      `CHECK(accumulator_q, 8'hA5)
      tally_and_finish();
   end
endmodule : test_data_move_multiply_exec
